/* File: pkg/cell_balance_pkg.sv */
`default_nettype none
package cell_balance_pkg;

   // Core clock and the base tick of the balancing logic
   localparam int CLK_FREQ_MHZ    = 100;     // Core clock rate
   localparam int TICK_TIME_US    = 62500;   // 62.5 ms channel stagger
   localparam int TICK_CYCLES_DEF = TICK_TIME_US * CLK_FREQ_MHZ;

   // Periods counted in base ticks
   localparam int SECOND_US       = 1000000; // One second
   localparam int PWM_PERIOD_S    = 30;      // PWM period
   localparam int WDT_TIME_S      = 2;       // Watchdog window
   localparam int TICKS_PER_S     = SECOND_US / TICK_TIME_US;
   localparam int PERIOD_TICKS    = PWM_PERIOD_S * TICKS_PER_S;
   localparam int HALF_TICKS      = PERIOD_TICKS / 2;
   // Longest on-window; two ticks short of half keeps neighbours apart
   localparam logic [8:0] ON_MAX_TICKS = 9'(HALF_TICKS - 2);
   localparam logic [5:0] WDT_TICKS = 6'(WDT_TIME_S * TICKS_PER_S);
   localparam logic [3:0] SEC_LAST  = 4'(TICKS_PER_S - 1);
   localparam logic [8:0] PHASE_LAST = 9'(PERIOD_TICKS - 1);

   // Register byte offsets on the bus
   localparam logic [7:0] ADDR_CFG_A  = 8'h00; // Config bytes 0..3
   localparam logic [7:0] ADDR_CFG_B  = 8'h04; // Config bytes 4..5
   localparam logic [7:0] ADDR_PWM    = 8'h08; // Six 4-bit duty settings
   localparam logic [7:0] ADDR_BRIDGE_REGISTER_A_L = 8'h0c; // Bridge bytes 0..3
   localparam logic [7:0] ADDR_BRIDGE_REGISTER_A_H = 8'h10; // Bridge bytes 4..5
   localparam logic [7:0] ADDR_STATUS = 8'h14; // Flags, write 1 to clear all but the watchdog flag
   localparam logic [7:0] ADDR_PING   = 8'h18; // Plain valid command

   // Field positions
   localparam int DCC_BYTE   = 4;  // Discharge control bits 5..0
   localparam int CTL_BYTE   = 5;  // Monitor enable and timeout code
   localparam int MON_EN_BIT = 3;  // Timer monitor enable
   localparam int DISCHARGE_TIMEOUT_SETTING_LSB   = 4;  // Timeout code in bits 7..4
   localparam int ST_OV_LSB  = 8;  // Overvoltage flags in status
   localparam int ST_RED_BIT = 16; // Redundancy failure flag
   localparam int ST_WDT_BIT = 17; // Watchdog expired
   localparam int ST_ST_LSB  = 18; // Balancing state

   // Reset values
   localparam logic [47:0] BRIDGE_REGISTER_A_RESET = 48'hffff_ffff_ffff;

   // Balancing states, Gray along standby, direct, extended, sleep
   typedef enum logic [1:0] {
      ST_STANDBY  = 2'b00,
      ST_ACTIVE   = 2'b01,
      ST_EXTENDED = 2'b11,
      ST_SLEEP    = 2'b10
   } bal_state_t;

   // Result of one monitor conversion
   typedef struct packed {
      logic [5:0] uv;       // Undervoltage per cell
      logic [5:0] ov;       // Overvoltage per cell
      logic       red_fail; // Redundancy check failed
   } mon_result_t;

   // Whole state of the controller
   typedef struct packed {
      bal_state_t       st;
      logic [5:0][7:0]  cfg;
      logic [5:0][3:0]  duty;
      logic [47:0]      bridge_register_a;
      logic [5:0]       uv_flag;
      logic [5:0]       ov_flag;
      logic             red_flag;
      logic [5:0]       wdt_cnt;
      logic             wdt_flag;
      logic [12:0]      remain;
      logic [31:0]      tick_cnt;
      logic [8:0]       phase;
      logic             conv_busy;
      logic             conv_start;
      logic [5:0]       sw;
      logic             hready;
      logic [31:0]      hrdata;
      logic             a_wr;
      logic             a_rd;
      logic [7:0]       a_addr;
   } ctrl_state_t;

   localparam ctrl_state_t CTRL_RESET = '{
      st: ST_STANDBY, cfg: '0, duty: '0, bridge_register_a: BRIDGE_REGISTER_A_RESET,
      uv_flag: '0, ov_flag: '0, red_flag: 1'b0, wdt_cnt: '0,
      wdt_flag: 1'b0, remain: '0, tick_cnt: '0, phase: '0,
      conv_busy: 1'b0, conv_start: 1'b0, sw: '0, hready: 1'b1,
      hrdata: '0, a_wr: 1'b0, a_rd: 1'b0, a_addr: '0};

   // Timeout code to seconds
   function automatic logic [12:0] discharge_timeout_setting_seconds(input logic [3:0] code);
      case (code)
         4'h1:    discharge_timeout_setting_seconds = 13'd30;
         4'h2:    discharge_timeout_setting_seconds = 13'd60;
         4'h3:    discharge_timeout_setting_seconds = 13'd120;
         4'h4:    discharge_timeout_setting_seconds = 13'd180;
         4'h5:    discharge_timeout_setting_seconds = 13'd240;
         4'h6:    discharge_timeout_setting_seconds = 13'd300;
         4'h7:    discharge_timeout_setting_seconds = 13'd600;
         4'h8:    discharge_timeout_setting_seconds = 13'd900;
         4'h9:    discharge_timeout_setting_seconds = 13'd1200;
         4'ha:    discharge_timeout_setting_seconds = 13'd1800;
         4'hb:    discharge_timeout_setting_seconds = 13'd2400;
         4'hc:    discharge_timeout_setting_seconds = 13'd3600;
         4'hd:    discharge_timeout_setting_seconds = 13'd4500;
         4'he:    discharge_timeout_setting_seconds = 13'd5400;
         4'hf:    discharge_timeout_setting_seconds = 13'd7200;
         default: discharge_timeout_setting_seconds = 13'd0;
      endcase
   endfunction : discharge_timeout_setting_seconds

endpackage : cell_balance_pkg
`default_nettype wire

/* File: rtl/cell_balance_pwm_reset_ctrl.sv */
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module cell_balance_pwm_reset_ctrl
   import cell_balance_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF // Cycles per 62.5 ms tick
)(
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        discharge_timer_enable_pin_i,
   input  wire logic        thermal_shutdown_i,
   input  wire logic        conv_done_i,
   input  wire mon_result_t mon_result_i,
   output logic      [5:0]  balance_switch_o,
   output logic      [1:0]  bal_state_o,
   output logic             watchdog_expired_o,
   output logic             conv_start_o
);

   ctrl_state_t q;          // Registered state
   ctrl_state_t next_q;     // Next state
   logic        tick;       // 62.5 ms tick
   logic        sec_tick;   // One-second tick
   logic        timer_run;  // Discharge timer counting
   logic        mon_en;     // Timer monitor enable
   logic        wdt_fire;   // Watchdog expiry event
   logic        cmd;        // Valid command this cycle
   logic        cfg_wr;     // Config write this cycle
   logic [3:0]  discharge_timeout_setting;       // Timeout code of next config

   // Position of a channel inside its 30 s period
   function automatic logic [8:0] pwm_pos(input logic [8:0] ph,
                                          input int ch);
      logic [9:0] off;
      off = 10'(ch) + ((ch % 2 == 1) ? 10'(HALF_TICKS) : 10'd0);
      if ({1'b0, ph} >= off)
         pwm_pos = 9'({1'b0, ph} - off);
      else
         pwm_pos = 9'({1'b0, ph} + 10'(PERIOD_TICKS) - off);
   endfunction : pwm_pos

   // Time-left code shown when the timeout code is read
   function automatic logic [3:0] discharge_timeout_setting_code(input logic [12:0] rem);
      discharge_timeout_setting_code = 4'h0;
      for (int c = 15; c >= 1; c--)
      begin
         if (rem != 13'd0 && rem <= discharge_timeout_setting_seconds(4'(c)))
            discharge_timeout_setting_code = 4'(c);
      end
   endfunction : discharge_timeout_setting_code

   // Reset all that a sleep entry clears
   function automatic ctrl_state_t go_sleep(input ctrl_state_t s);
      go_sleep           = s;
      go_sleep.st        = ST_SLEEP;
      go_sleep.cfg       = '0;
      go_sleep.duty      = '0;
      go_sleep.bridge_register_a      = BRIDGE_REGISTER_A_RESET;
      go_sleep.remain    = '0;
      go_sleep.conv_busy = 1'b0;
   endfunction : go_sleep

   assign mon_en    = q.cfg[CTL_BYTE][MON_EN_BIT];
   assign timer_run = discharge_timer_enable_pin_i && (q.remain != 13'd0);

   // Next-state logic
   always_comb
   begin
      next_q            = q;
      next_q.conv_start = 1'b0;
      next_q.a_wr       = 1'b0;
      next_q.a_rd       = 1'b0;
      next_q.hready     = 1'b1;
      cmd               = 1'b0;
      cfg_wr            = 1'b0;
      discharge_timeout_setting              = 4'h0;
      // Base tick and one-second tick
      tick     = (q.tick_cnt == 32'(TICK_CYCLES - 1));
      sec_tick = tick && (q.phase[3:0] == SEC_LAST);
      next_q.tick_cnt = tick ? 32'd0 : q.tick_cnt + 32'd1;
      if (tick)
         next_q.phase = (q.phase == PHASE_LAST) ? 9'd0 : q.phase + 9'd1;

      // Watchdog saturates one past its window
      wdt_fire = tick && (q.wdt_cnt == WDT_TICKS) &&
                 (q.st == ST_ACTIVE || q.st == ST_STANDBY);
      if (tick && q.wdt_cnt <= WDT_TICKS)
         next_q.wdt_cnt = q.wdt_cnt + 6'd1;
      if (wdt_fire)
      begin
         if (timer_run)
         begin
            next_q.st     = ST_EXTENDED;
            next_q.cfg[0] = 8'h00;
            if (!mon_en)
               next_q.cfg[3:1] = '0;
            next_q.bridge_register_a   = BRIDGE_REGISTER_A_RESET;
         end
         else
            next_q = go_sleep(next_q);
      end

      // Discharge timer counts whole seconds down
      if (sec_tick && timer_run)
      begin
         next_q.remain = q.remain - 13'd1;
         if (q.remain == 13'd1)
         begin
            if (q.wdt_cnt > WDT_TICKS)
               next_q = go_sleep(next_q);
            else
            begin
               next_q.duty = '0;
               next_q.cfg[DCC_BYTE] = 8'h00;
               next_q.cfg[CTL_BYTE] = 8'h00;
               if (mon_en)
                  next_q.cfg[3:1] = '0;
            end
         end
      end

      // Thermal shutdown
      if (thermal_shutdown_i)
      begin
         next_q.cfg    = '0;
         next_q.bridge_register_a   = BRIDGE_REGISTER_A_RESET;
         next_q.remain = '0;
      end

      // Bus write commits in its data phase
      if (q.a_wr)
      begin
         cmd = 1'b1;
         case (q.a_addr)
            ADDR_CFG_A:
            begin
               next_q.cfg[3:0] = hwdata_i;
               cfg_wr = 1'b1;
            end
            ADDR_CFG_B:
            begin
               next_q.cfg[5:4] = hwdata_i[15:0];
               cfg_wr = 1'b1;
            end
            ADDR_PWM:    next_q.duty = hwdata_i[23:0];
            ADDR_BRIDGE_REGISTER_A_L: next_q.bridge_register_a[31:0] = hwdata_i;
            ADDR_BRIDGE_REGISTER_A_H: next_q.bridge_register_a[47:32] = hwdata_i[15:0];
            ADDR_STATUS:
            begin
               next_q.uv_flag  = q.uv_flag & ~hwdata_i[5:0];
               next_q.ov_flag  = q.ov_flag & ~hwdata_i[ST_OV_LSB +: 6];
               next_q.red_flag = q.red_flag & ~hwdata_i[ST_RED_BIT];
            end
            ADDR_PING:   cmd = 1'b1;
            default:     cmd = 1'b0;
         endcase
      end
      // A valid command restarts the watchdog and wakes the block
      if (cmd)
      begin
         next_q.wdt_cnt = '0;
         next_q.st      = ST_ACTIVE;
      end
      // Only a config write reloads the discharge timer
      if (cfg_wr)
      begin
         discharge_timeout_setting = next_q.cfg[CTL_BYTE][DISCHARGE_TIMEOUT_SETTING_LSB +: 4];
         if (discharge_timer_enable_pin_i && discharge_timeout_setting != 4'h0)
            next_q.remain = discharge_timeout_setting_seconds(discharge_timeout_setting);
         else
            next_q.remain = '0;
      end
      next_q.wdt_flag = (next_q.wdt_cnt > WDT_TICKS);

      // Monitor start once per period while balancing by PWM with the monitor enabled
      if (q.st == ST_EXTENDED && mon_en && tick &&
          q.phase == PHASE_LAST && !q.conv_busy)
      begin
         next_q.conv_start = 1'b1;
         next_q.conv_busy  = 1'b1;
      end
      // Monitor result; flag sets win over a clear
      if (conv_done_i && q.conv_busy)
      begin
         next_q.conv_busy = 1'b0;
         next_q.uv_flag   = next_q.uv_flag | mon_result_i.uv;
         next_q.ov_flag   = next_q.ov_flag | mon_result_i.ov;
         for (int i = 0; i < 6; i++)
         begin
            if (mon_result_i.uv[i])
               next_q.duty[i] = 4'h0;
         end
         if (mon_result_i.red_fail)
         begin
            next_q.red_flag = 1'b1;
            next_q.duty     = '0;
            next_q.remain   = '0;
         end
      end

      // Switch drive
      for (int i = 0; i < 6; i++)
      begin
         case (q.st)
            ST_ACTIVE, ST_STANDBY:
               next_q.sw[i] = q.cfg[DCC_BYTE][i];
            // Full setting trimmed so adjacent windows never touch
            ST_EXTENDED:
               next_q.sw[i] = q.cfg[DCC_BYTE][i] &&
                  discharge_timer_enable_pin_i &&
                  (pwm_pos(q.phase, i) < {1'b0, q.duty[i], 4'h0}) &&
                  (pwm_pos(q.phase, i) < ON_MAX_TICKS);
            default:
               next_q.sw[i] = 1'b0;
         endcase
      end

      // Bus address phase; reads take one wait state
      if (hsel_i && htrans_i[1] && hready_i)
      begin
         next_q.a_addr = haddr_i[7:0];
         next_q.a_wr   = hwrite_i;
         next_q.a_rd   = !hwrite_i;
         next_q.hready = hwrite_i;
      end
      if (q.a_rd)
      begin
         case (q.a_addr)
            ADDR_CFG_A:  next_q.hrdata = q.cfg[3:0];
            ADDR_CFG_B:  next_q.hrdata = {16'h0000,
                            discharge_timeout_setting_code(timer_run ? q.remain : 13'd0),
                            q.cfg[CTL_BYTE][DISCHARGE_TIMEOUT_SETTING_LSB-1:0],
                            q.cfg[DCC_BYTE]};
            ADDR_PWM:    next_q.hrdata = {8'h00, q.duty};
            ADDR_BRIDGE_REGISTER_A_L: next_q.hrdata = q.bridge_register_a[31:0];
            ADDR_BRIDGE_REGISTER_A_H: next_q.hrdata = {16'h0000, q.bridge_register_a[47:32]};
            ADDR_STATUS: next_q.hrdata = {12'h000, q.st, q.wdt_flag,
                            q.red_flag, 2'b00, q.ov_flag, 2'b00,
                            q.uv_flag};
            default:     next_q.hrdata = 32'h0000_0000;
         endcase
      end
   end

   // State register
   always_ff @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
         q <= CTRL_RESET;
      else
         q <= next_q;
   end

   // Outputs straight from the state register, hresp_o tied low
   assign hrdata_o           = q.hrdata;
   assign hreadyout_o        = q.hready;
   assign hresp_o            = 1'b0;
   assign balance_switch_o   = q.sw;
   assign bal_state_o        = q.st;
   assign watchdog_expired_o = q.wdt_flag;
   assign conv_start_o       = q.conv_start;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_reset_standby;
      $rose(reset_n_i) |-> q.st == ST_STANDBY && q.sw == 6'h00;
   endproperty
   a_reset_standby: assert property (p_reset_standby)
      else $error("State not standby after reset");

   property p_thermal;
      thermal_shutdown_i && !q.a_wr |=> q.cfg == '0 ##1 q.sw == 6'h00;
   endproperty
   a_thermal: assert property (p_thermal)
      else $error("Thermal shutdown left config or switches");

   property p_wdt_ext;
      wdt_fire && timer_run && !q.a_wr && !thermal_shutdown_i
         |=> q.st == ST_EXTENDED && q.cfg[0] == 8'h00;
   endproperty
   a_wdt_ext: assert property (p_wdt_ext)
      else $error("Watchdog with timer did not extend");

   property p_wdt_sleep;
      wdt_fire && !timer_run && !q.a_wr
         |=> q.st == ST_SLEEP && q.duty == '0 && q.cfg == '0;
   endproperty
   a_wdt_sleep: assert property (p_wdt_sleep)
      else $error("Watchdog without timer did not sleep");

   property p_direct;
      q.st == ST_ACTIVE |=> q.sw == $past(q.cfg[DCC_BYTE][5:0]);
   endproperty
   a_direct: assert property (p_direct)
      else $error("Switches not following control bits");

   property p_adjacent;
      q.st == ST_EXTENDED |=> (q.sw & {1'b0, q.sw[5:1]}) == 6'h00;
   endproperty
   a_adjacent: assert property (p_adjacent)
      else $error("Adjacent switches on together");

   property p_zero_duty;
      q.st == ST_EXTENDED && q.duty[0] == 4'h0 |=> !q.sw[0];
   endproperty
   a_zero_duty: assert property (p_zero_duty)
      else $error("Switch on with zero duty");

   property p_sleep_duty;
      q.st != ST_SLEEP ##1 q.st == ST_SLEEP |-> q.duty == '0;
   endproperty
   a_sleep_duty: assert property (p_sleep_duty)
      else $error("Duty not cleared on sleep entry");

   property p_wdt_window;
      cmd ##1 !cmd [*8] |-> !q.wdt_flag;
   endproperty
   a_wdt_window: assert property (p_wdt_window)
      else $error("Watchdog expired too early");

   property p_uv_clear;
      conv_done_i && q.conv_busy && mon_result_i.uv[0] && !q.a_wr
         |=> q.duty[0] == 4'h0;
   endproperty
   a_uv_clear: assert property (p_uv_clear)
      else $error("Undervoltage cell kept its duty");

   property p_red_fail;
      conv_done_i && q.conv_busy && mon_result_i.red_fail && !q.a_wr
         |=> q.duty == '0 && q.remain == 13'd0;
   endproperty
   a_red_fail: assert property (p_red_fail)
      else $error("Redundancy failure did not end discharge");

   property p_conv_when;
      conv_start_o |-> $past(q.st) == ST_EXTENDED && $past(mon_en);
   endproperty
   a_conv_when: assert property (p_conv_when)
      else $error("Conversion started outside monitoring");

endmodule : cell_balance_pwm_reset_ctrl
`default_nettype wire

/* File: testbench/cell_balance_pwm_reset_ctrl_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module cell_balance_pwm_reset_ctrl_tb
   import cell_balance_pkg::*;
;
   logic        sys_clk, reset_n, hsel, hwrite, rdy, pin, thermal;
   logic        done, wdt, cstart;
   logic [1:0]  htrans, st;
   logic [31:0] haddr, hwdata, hrdata, rd, seed, cfg;
   logic [23:0] duty;
   logic [5:0]  sw, sw_p, dcc;
   logic [3:0]  dly;
   mon_result_t res, mres;
   int          n_mismatch, num_checks, wn, cyc, c_last, c_gap, ext_n;
   int          on_n [6];

   cell_balance_pwm_reset_ctrl #(.TICK_CYCLES(4)) dut_u (
      .sys_clk_i (sys_clk), .reset_n_i (reset_n), .hsel_i (hsel),
      .haddr_i (haddr), .htrans_i (htrans), .hwrite_i (hwrite),
      .hsize_i (3'b010), .hwdata_i (hwdata), .hready_i (rdy),
      .hrdata_o (hrdata), .hreadyout_o (rdy), .hresp_o (),
      .discharge_timer_enable_pin_i (pin), .thermal_shutdown_i (thermal),
      .conv_done_i (done), .mon_result_i (mres), .balance_switch_o (sw),
      .bal_state_o (st), .watchdog_expired_o (wdt), .conv_start_o (cstart));

   mon_conv_model conv_u (.clk_i (sys_clk), .rst_n_i (reset_n),
      .start_i (cstart), .delay_i (dly), .res_i (res), .done_o (done),
      .res_o (mres));

   // Free running clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Compare one value
   task automatic chk(input logic [31:0] g, e, input string m);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk

   // Counts and verdict
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out

   // Bound ran out
   task automatic hang(input string m);
      n_mismatch++;
      $display("ERROR t=%0t timeout %s", $time, m);
      close_out();
   endtask : hang

   // Hold until ready is seen high at a falling edge, then step to the next rising edge
   task automatic rdy_w();
      int k;
      k = 0;
      @(negedge sys_clk);
      while (rdy !== 1'b1 && k < 50)
      begin
         k++;
         @(negedge sys_clk);
      end
      if (k == 50)
         hang("bus");
      rd = hrdata;
      @(posedge sys_clk);
   endtask : rdy_w

   // One single word transfer
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      rdy_w();
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= d;
      rdy_w();
   endtask : bus

   // Read and compare
   task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                       input string m);
      bus(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask : rchk

   // Wait for a balancing state
   task automatic wait_st(input logic [1:0] s, input int b);
      wn = 0;
      while (st !== s && wn < b)
      begin
         wn++;
         @(negedge sys_clk);
      end
      if (wn == b)
         hang("state");
   endtask : wait_st

   // Wait for a conversion request
   task automatic wait_cs();
      wn = 0;
      while (cstart !== 1'b1 && wn < 2500)
      begin
         wn++;
         @(negedge sys_clk);
      end
      if (wn == 2500)
         hang("conversion");
      repeat (20) @(negedge sys_clk);
   endtask : wait_cs

   // Switch-on cycles in one period, window capped beside neighbours
   function automatic int on_cyc(input logic [3:0] d);
      on_cyc = TICKS_PER_S * d;
      if (on_cyc > ON_MAX_TICKS)
         on_cyc = ON_MAX_TICKS;
      on_cyc = on_cyc * 4;
   endfunction : on_cyc

   // Duty word left after undervoltage clearing, all cells at 5
   function automatic logic [31:0] duty_left(input logic [5:0] uv);
      duty_left = 32'h0;
      for (int i = 0; i < 6; i++)
         duty_left[4*i +: 4] = uv[i] ? 4'h0 : 4'h5;
   endfunction : duty_left

   // Switch watcher while balancing by PWM, request spacing
   always @(negedge sys_clk)
   begin
      cyc++;
      ext_n = (st === 2'b11) ? ext_n + 1 : 0;
      if (cstart === 1'b1)
      begin
         c_gap  = cyc - c_last;
         c_last = cyc;
      end
      if (ext_n > 2 && sw !== sw_p)
      begin
         chk({26'h0, sw & (sw >> 1)}, 0, "adjacent on");
         chk({26'h0, sw & ~sw_p & ((sw_p << 1) | (sw_p >> 1))}, 0,
             "no gap");
         chk({31'h0, $countones(sw & ~sw_p) > 1}, 0, "joint on");
      end
      sw_p = sw;
   end

   // Main sequence
   initial
   begin
      seed = 32'h4765e8b3;
      {reset_n, hsel, hwrite, pin, thermal} = '0;
      {htrans, haddr, hwdata, res, sw_p} = '0;
      {n_mismatch, num_checks, cyc, c_last, c_gap, ext_n} = '0;
      dly = 4'h0;
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(negedge sys_clk);
      chk({24'h0, sw, st}, 0, "reset outputs");
      rchk(ADDR_CFG_A, 0, "cfg reset");
      rchk(ADDR_PWM, 0, "duty reset");
      rchk(ADDR_BRIDGE_REGISTER_A_L, 32'hffffffff, "bridge reset");
      rchk(8'h1c, 0, "unmapped");
      $display("test reset done");
      // Direct control, then watchdog with no timer
      bus(1'b1, ADDR_PWM, $random(seed));
      bus(1'b1, ADDR_BRIDGE_REGISTER_A_L, $random(seed));
      repeat (4)
      begin
         dcc = 6'($random(seed));
         bus(1'b1, ADDR_CFG_B, {26'h0, dcc});
         repeat (2) @(negedge sys_clk);
         chk({26'h0, sw}, {26'h0, dcc}, "direct");
      end
      wait_st(2'b10, 200);
      chk({31'h0, wn >= 120 && wn <= 136}, 1, "watchdog time");
      @(negedge sys_clk);
      chk({25'h0, sw, wdt}, 1, "sleep outputs");
      rchk(ADDR_PWM, 0, "duty sleep");
      rchk(ADDR_CFG_B, 0, "cfg sleep");
      rchk(ADDR_BRIDGE_REGISTER_A_L, 32'hffffffff, "bridge sleep");
      $display("test watchdog done");
      // Extended balancing, on-time per cell
      pin  <= 1'b1;
      duty = 24'($random(seed));
      duty[3:0]  = 4'hf;
      duty[11:8] = 4'h0;
      bus(1'b1, ADDR_PWM, {8'h0, duty});
      bus(1'b1, ADDR_BRIDGE_REGISTER_A_L, 32'h0);
      bus(1'b1, ADDR_CFG_A, $random(seed));
      bus(1'b1, ADDR_CFG_B, 32'h00002037);
      wait_st(2'b11, 200);
      rchk(ADDR_CFG_A, 0, "cfg extended");
      rchk(ADDR_BRIDGE_REGISTER_A_L, 32'hffffffff, "bridge extended");
      for (int i = 0; i < 6; i++)
         on_n[i] = 0;
      repeat (1920)
      begin
         @(negedge sys_clk);
         for (int i = 0; i < 6; i++)
            on_n[i] += sw[i];
      end
      for (int i = 0; i < 6; i++)
         chk(on_n[i], (i == 3) ? 0 : on_cyc(duty[4*i +: 4]), "on");
      wait_st(2'b10, 4000);
      @(negedge sys_clk);
      chk({26'h0, sw}, 0, "timeout off");
      rchk(ADDR_PWM, 0, "duty timeout");
      rchk(ADDR_CFG_B, 0, "cfg timeout");
      $display("test pwm done");
      // Monitor: undervoltage then redundancy failure
      cfg = $random(seed);
      bus(1'b1, ADDR_PWM, 32'h00555555);
      bus(1'b1, ADDR_CFG_A, cfg);
      bus(1'b1, ADDR_CFG_B, 32'h0000383f);
      wait_st(2'b11, 200);
      rchk(ADDR_CFG_A, {cfg[31:8], 8'h0}, "bytes kept");
      res = 13'($random(seed)) & 13'h1ffe;
      wait_cs();
      rchk(ADDR_STATUS, {14'h3, 4'h8, res.ov, 2'h0, res.uv},
           "flags");
      rchk(ADDR_PWM, duty_left(res.uv), "uv cleared");
      res.red_fail = 1'b1;
      dly = 4'hf;
      wait_cs();
      chk(c_gap, 1920, "monitor period");
      chk({26'h0, sw}, 0, "red off");
      rchk(ADDR_PWM, 0, "red duty");
      $display("test monitor done");
      // Wake, then thermal event
      bus(1'b1, ADDR_PING, 32'h0);
      @(negedge sys_clk);
      chk({30'h0, st}, 1, "wake");
      bus(1'b1, ADDR_CFG_B, 32'h3f);
      bus(1'b1, ADDR_BRIDGE_REGISTER_A_H, 32'h1234);
      @(posedge sys_clk);
      thermal <= 1'b1;
      @(posedge sys_clk);
      thermal <= 1'b0;
      repeat (2) @(negedge sys_clk);
      chk({26'h0, sw}, 0, "thermal off");
      rchk(ADDR_CFG_B, 0, "thermal cfg");
      rchk(ADDR_BRIDGE_REGISTER_A_H, 32'h0000ffff, "thermal bridge");
      $display("test thermal done");
      // Timer ends while commands keep the watchdog alive
      cfg = $random(seed);
      bus(1'b1, ADDR_PWM, $random(seed));
      bus(1'b1, ADDR_CFG_A, cfg);
      bus(1'b1, ADDR_CFG_B, 32'h0000183f);
      repeat (40)
      begin
         repeat (50) @(negedge sys_clk);
         bus(1'b1, ADDR_PING, 32'h0);
      end
      @(negedge sys_clk);
      chk({23'h0, sw, wdt, st}, 1, "early timeout");
      rchk(ADDR_CFG_B, 0, "bytes 4 5");
      rchk(ADDR_PWM, 0, "duty early");
      rchk(ADDR_CFG_A, {24'h0, cfg[7:0]}, "bytes 1 3");
      $display("test early timeout done");
      close_out();
   end
endmodule : cell_balance_pwm_reset_ctrl_tb
`default_nettype wire

/* File: testbench/mon_conv_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Cell converter beside the block: answers each start after a delay
module mon_conv_model
   import cell_balance_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        start_i,
   input  wire logic [3:0]  delay_i,
   input  wire mon_result_t res_i,
   output logic             done_o,
   output mon_result_t      res_o
);
   logic [4:0] cnt; // Cycles left of a conversion

   // Result lines change every cycle unless done is up
   always_ff @(posedge clk_i)
   begin
      done_o <= 1'b0;
      res_o  <= ~res_o;
      if (!rst_n_i)
      begin
         cnt   <= '0;
         res_o <= '0;
      end
      else if (start_i)
         cnt <= {1'b0, delay_i} + 5'd1;
      else if (cnt != 5'd0)
      begin
         cnt <= cnt - 5'd1;
         if (cnt == 5'd1)
         begin
            done_o <= 1'b1;
            res_o  <= res_i;
         end
      end
   end
endmodule : mon_conv_model
`default_nettype wire
